// *** splat_pkg.sv ***
// Constants, register map and modes for the storage protection latch.
// Assumes a single 250 MHz clock and an Avalon-MM slave with waitrequest.
package splat_pkg;
  // ==========================================================================
  // Sizes
  localparam int NREG = 4;
  localparam int AW   = 32;
  localparam int DW   = 32;
  localparam int BAW  = 8;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CFG    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MK = 8'h10;
  localparam logic [7:0] OFS_LOGA   = 8'h14;
  localparam logic [7:0] OFS_LOGI   = 8'h18;
  localparam logic [7:0] OFS_RGN    = 8'h40;
  // Region area: 8 bytes per region, start then end
  localparam logic [7:0] RGN_SPAN   = 8'h20;
  // ==========================================================================
  // Field positions
  localparam int CTRL_ACT  = 0;
  localparam int CFG_MODE  = 0;
  localparam int CFG_RRSP  = 2;
  localparam int CFG_WRSP  = 4;
  localparam int CFG_LOG   = 5;
  localparam int CFG_RVAL  = 8;
  localparam int IRQ_BR    = 0;
  localparam int IRQ_BW    = 1;
  localparam int IRQ_REJ   = 2;
  // ==========================================================================
  // Reset values and constants
  localparam logic [DW-1:0] CFG_RST   = 32'h0000_0060;
  localparam logic [DW-1:0] PATTERN   = 32'hdead_0000;
  localparam logic [DW-1:0] LFSR_SEED = 32'h1234_5678;
  localparam logic [DW-1:0] LFSR_TAPS = 32'h8020_0003;
  // ==========================================================================
  // Encodings
  typedef enum logic [1:0]
  {
    SPL_BLK_RD = 2'h0,
    SPL_BLK_WR = 2'h1,
    SPL_BLK_RW = 2'h2
  } splat_mode_t;
  typedef enum logic [1:0]
  {
    SPL_LOG_RD   = 2'h0,
    SPL_LOG_WR   = 2'h1,
    SPL_LOG_BOTH = 2'h2,
    SPL_LOG_NONE = 2'h3
  } splat_log_t;
  typedef enum logic [0:0]
  {
    SPL_INACTIVE = 1'h0,
    SPL_ACTIVE   = 1'h1
  } splat_state_t;
  localparam logic [1:0] RRSP_PAT = 2'h0;
  localparam logic [1:0] RRSP_RND = 2'h1;
  localparam logic [1:0] RRSP_ERR = 2'h2;
endpackage

// *** splat_top.sv ***
// Storage protection latch: Avalon-MM register slave plus access filter.
// Assumes the storage sits behind the mst/mem ports, answering mem_rdata
// combinationally in the cycle of the request; rst_i is the Initialize Signal.
module splat_top
  import splat_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic [BAW-1:0] avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [3:0]    avs_byteenable_i,
  input  wire logic [DW-1:0] avs_writedata_i,
  output logic      [DW-1:0] avs_readdata_o,
  output logic               avs_waitrequest_o,
  output logic      [1:0]    avs_response_o,
  input  wire logic          acc_valid_i,
  input  wire logic          acc_write_i,
  input  wire logic [AW-1:0] acc_addr_i,
  input  wire logic [DW-1:0] acc_wdata_i,
  input  wire logic          peer_block_rd_i,
  input  wire logic          peer_block_wr_i,
  output logic               acc_done_o,
  output logic      [DW-1:0] acc_rdata_o,
  output logic               acc_error_o,
  output logic               mem_write_o,
  output logic      [AW-1:0] mem_addr_o,
  output logic      [DW-1:0] mem_wdata_o,
  input  wire logic [DW-1:0] mem_rdata_i,
  output logic               active_o,
  output logic               irq_o
);
  // ==========================================================================
  // Functions
  function automatic logic in_rgn(input logic [AW-1:0] a,
                                  input logic [AW-1:0] s,
                                  input logic [AW-1:0] e,
                                  input logic          v);
    in_rgn = v && (a >= s) && (a <= e);
  endfunction
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o,
                                          input logic [DW-1:0] n,
                                          input logic [3:0]    be);
    logic [DW-1:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = n[b*8 +: 8];
    merge = r;
  endfunction
  // ==========================================================================
  // State
  splat_state_t  st_reg;
  logic [DW-1:0] cfg_reg;
  logic [AW-1:0] rs_reg [NREG];
  logic [AW-1:0] re_reg [NREG];
  logic [NREG-1:0] rv_reg;
  logic [2:0]    ist_reg;
  logic [2:0]    imk_reg;
  logic [AW-1:0] loga_reg;
  logic [DW-1:0] logi_reg;
  logic [DW-1:0] lfsr_reg;
  logic          ack_reg;
  // ==========================================================================
  // Bus decode; every access answers one cycle after it is presented
  logic          bus_req;
  logic          bus_wr;
  logic          bus_rd;
  logic          is_rgn;
  logic [1:0]    rgn_idx;
  logic          rgn_end;
  logic          hit_ctrl;
  logic          hit_cfg;
  logic          hit_ist;
  logic          hit_imk;
  logic          hit_known;
  assign bus_req  = (avs_read_i | avs_write_i) & ~ack_reg;
  assign bus_wr   = avs_write_i & ~ack_reg;
  assign bus_rd   = avs_read_i & ~ack_reg;
  assign is_rgn   = (avs_address_i >= OFS_RGN) &&
                    (avs_address_i < OFS_RGN + RGN_SPAN) &&
                    (avs_address_i[1:0] == 2'h0);
  assign rgn_idx  = avs_address_i[4:3];
  assign rgn_end  = avs_address_i[2];
  assign hit_ctrl = avs_address_i == OFS_CTRL;
  assign hit_cfg  = avs_address_i == OFS_CFG;
  assign hit_ist  = avs_address_i == OFS_IRQ_ST;
  assign hit_imk  = avs_address_i == OFS_IRQ_MK;
  assign hit_known = hit_ctrl | hit_cfg | hit_ist | hit_imk | is_rgn |
                     (avs_address_i == OFS_STATUS) |
                     (avs_address_i == OFS_LOGA) |
                     (avs_address_i == OFS_LOGI);
  // ==========================================================================
  // Configuration acceptance: Active only allows a region to grow
  logic [DW-1:0] cfg_new;
  logic [AW-1:0] rgn_old;
  logic [AW-1:0] rgn_new;
  logic          grow_ok;
  logic          cfg_ok;
  logic          rgn_ok;
  logic          rejected;
  assign cfg_new = merge(cfg_reg, avs_writedata_i, avs_byteenable_i);
  assign rgn_old = rgn_end ? re_reg[rgn_idx] : rs_reg[rgn_idx];
  assign rgn_new = merge(rgn_old, avs_writedata_i, avs_byteenable_i);
  // Start may only move down, end only up; an unused slot is free to claim
  assign grow_ok = !rv_reg[rgn_idx] ||
                   (rgn_end ? (rgn_new >= rgn_old) : (rgn_new <= rgn_old));
  assign cfg_ok  = (st_reg == SPL_INACTIVE) || (cfg_new == cfg_reg);
  assign rgn_ok  = (st_reg == SPL_INACTIVE) || grow_ok;
  assign rejected = bus_wr & ((hit_cfg & ~cfg_ok) | (is_rgn & ~rgn_ok));
  // ==========================================================================
  // Access filter
  logic [NREG-1:0] hits;
  logic          covered;
  logic          own_rd;
  logic          own_wr;
  logic          blk_rd;
  logic          blk_wr;
  logic          blk;
  logic [1:0]    mode;
  logic [1:0]    rrsp;
  logic [1:0]    lgm;
  always_comb
  begin
    for (int i = 0; i < NREG; i++)
      hits[i] = in_rgn(acc_addr_i, rs_reg[i], re_reg[i], rv_reg[i]);
  end
  assign mode    = cfg_reg[CFG_MODE +: 2];
  assign rrsp    = cfg_reg[CFG_RRSP +: 2];
  assign lgm     = cfg_reg[CFG_LOG +: 2];
  assign covered = |hits;
  assign own_rd  = (st_reg == SPL_ACTIVE) & covered &
                   ((mode == SPL_BLK_RD) | (mode == SPL_BLK_RW));
  assign own_wr  = (st_reg == SPL_ACTIVE) & covered &
                   ((mode == SPL_BLK_WR) | (mode == SPL_BLK_RW));
  assign blk_rd  = acc_valid_i & ~acc_write_i &
                   (own_rd | peer_block_rd_i);
  assign blk_wr  = acc_valid_i & acc_write_i &
                   (own_wr | peer_block_wr_i);
  assign blk     = blk_rd | blk_wr;
  logic          log_rd;
  logic          log_wr;
  assign log_rd  = blk_rd & ((lgm == SPL_LOG_RD) | (lgm == SPL_LOG_BOTH));
  assign log_wr  = blk_wr & ((lgm == SPL_LOG_WR) | (lgm == SPL_LOG_BOTH));
  // Blocked read data never touch mem_rdata_i
  logic [DW-1:0] blk_data;
  assign blk_data = (rrsp == RRSP_RND) ? lfsr_reg :
                    (rrsp == RRSP_PAT) ? PATTERN : '0;
  // ==========================================================================
  // Latch state: set by activate, cleared only by rst_i
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_reg <= SPL_INACTIVE;
    else if (bus_wr & hit_ctrl & avs_byteenable_i[0] &
             avs_writedata_i[CTRL_ACT])
      st_reg <= SPL_ACTIVE;
  end
  // Configuration and regions
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_reg <= CFG_RST;
      rv_reg  <= '0;
      for (int i = 0; i < NREG; i++)
      begin
        rs_reg[i] <= '0;
        re_reg[i] <= '0;
      end
    end
    else if (bus_wr & hit_cfg & cfg_ok)
      cfg_reg <= cfg_new;
    else if (bus_wr & is_rgn & rgn_ok)
    begin
      if (rgn_end)
        re_reg[rgn_idx] <= rgn_new;
      else
        rs_reg[rgn_idx] <= rgn_new;
      if (cfg_reg[CFG_RVAL + 32'(rgn_idx)] == 1'b0 && st_reg == SPL_INACTIVE)
        rv_reg[rgn_idx] <= 1'b0;
      else
        rv_reg[rgn_idx] <= 1'b1;
    end
    else if (st_reg == SPL_INACTIVE)
      rv_reg <= cfg_reg[CFG_RVAL +: NREG];
  end
  // Sticky events, set wins over write-one-clear; log capture
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ist_reg  <= '0;
      imk_reg  <= '0;
      loga_reg <= '0;
      logi_reg <= '0;
    end
    else
    begin
      ist_reg <= (ist_reg & ~((bus_wr & hit_ist) ? avs_writedata_i[2:0] :
                              3'h0)) |
                 {rejected, log_wr, log_rd};
      if (bus_wr & hit_imk)
        imk_reg <= avs_writedata_i[2:0];
      if (log_rd | log_wr)
      begin
        loga_reg <= acc_addr_i;
        logi_reg <= logi_reg + 32'h1;
      end
    end
  end
  // Random source for blocked reads
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lfsr_reg <= LFSR_SEED;
    else
      lfsr_reg <= {lfsr_reg[DW-2:0], ^(lfsr_reg & LFSR_TAPS)};
  end
  // ==========================================================================
  // Bus read mux
  logic [DW-1:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    if (is_rgn)
      rd_mux = rgn_old;
    else
      case (avs_address_i)
        OFS_CTRL:   rd_mux = {31'h0, st_reg};
        OFS_CFG:    rd_mux = cfg_reg;
        OFS_STATUS: rd_mux = {{(DW-NREG-1){1'b0}}, rv_reg, st_reg};
        OFS_IRQ_ST: rd_mux = {29'h0, ist_reg};
        OFS_IRQ_MK: rd_mux = {29'h0, imk_reg};
        OFS_LOGA:   rd_mux = loga_reg;
        OFS_LOGI:   rd_mux = logi_reg;
        default:    rd_mux = '0;
      endcase
  end
  // Bus answer register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg           <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= '0;
      avs_response_o    <= 2'h0;
    end
    else
    begin
      ack_reg        <= bus_req;
      // Registered copy of the inverted acknowledge, low only in answer cycle
      avs_waitrequest_o <= ~bus_req;
      avs_readdata_o <= bus_rd ? rd_mux : '0;
      avs_response_o <= (bus_req & (~hit_known | rejected)) ? 2'h3 : 2'h0;
    end
  end
  // ==========================================================================
  // Storage side: pass or block each access, answer registered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_done_o  <= 1'b0;
      acc_rdata_o <= '0;
      acc_error_o <= 1'b0;
      mem_write_o <= 1'b0;
      mem_addr_o  <= '0;
      mem_wdata_o <= '0;
      active_o    <= 1'b0;
      irq_o       <= 1'b0;
    end
    else
    begin
      acc_done_o  <= acc_valid_i;
      acc_rdata_o <= blk_rd ? blk_data :
                     (acc_valid_i & ~acc_write_i) ? mem_rdata_i : '0;
      acc_error_o <= (blk_rd & (rrsp == RRSP_ERR)) |
                     (blk_wr & cfg_reg[CFG_WRSP]);
      mem_write_o <= acc_valid_i & acc_write_i & ~blk;
      mem_addr_o  <= acc_addr_i;
      mem_wdata_o <= acc_wdata_i;
      active_o    <= st_reg == SPL_ACTIVE;
      irq_o       <= |(ist_reg & imk_reg);
    end
  end
  // ==========================================================================
  // Checks
  property p_no_deact;
    @(posedge clk_i) disable iff (rst_i)
      st_reg == SPL_ACTIVE |=> st_reg == SPL_ACTIVE;
  endproperty
  a_no_deact: assert property (p_no_deact)
    else $error("latch left Active without reset");
  property p_reset_inactive;
    @(posedge clk_i) rst_i |=> st_reg == SPL_INACTIVE && rv_reg == '0;
  endproperty
  a_reset_inactive: assert property (p_reset_inactive)
    else $error("reset did not clear latch");
  property p_blk_wr_drop;
    @(posedge clk_i) disable iff (rst_i)
      blk_wr |=> !mem_write_o && acc_done_o;
  endproperty
  a_blk_wr_drop: assert property (p_blk_wr_drop)
    else $error("blocked write reached storage");
  property p_no_leak;
    @(posedge clk_i) disable iff (rst_i)
      blk_rd && rrsp == RRSP_PAT |=> acc_rdata_o == PATTERN;
  endproperty
  a_no_leak: assert property (p_no_leak)
    else $error("blocked read did not return pattern");
  property p_cfg_frozen;
    @(posedge clk_i) disable iff (rst_i)
      st_reg == SPL_ACTIVE ##1 st_reg == SPL_ACTIVE |->
        cfg_reg == $past(cfg_reg);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("configuration changed while Active");
  property p_keep_bind;
    @(posedge clk_i) disable iff (rst_i)
      st_reg == SPL_ACTIVE ##1 st_reg == SPL_ACTIVE |->
        (rv_reg & $past(rv_reg)) == $past(rv_reg);
  endproperty
  a_keep_bind: assert property (p_keep_bind)
    else $error("binding released while Active");
  property p_inactive_pass;
    @(posedge clk_i) disable iff (rst_i)
      acc_valid_i && acc_write_i && st_reg == SPL_INACTIVE &&
      !peer_block_wr_i |=> mem_write_o;
  endproperty
  a_inactive_pass: assert property (p_inactive_pass)
    else $error("write blocked while Inactive");
  property p_rd_err;
    @(posedge clk_i) disable iff (rst_i)
      blk_rd && rrsp == RRSP_ERR |=> acc_error_o && acc_rdata_o == '0;
  endproperty
  a_rd_err: assert property (p_rd_err)
    else $error("blocked read error answer wrong");
  property p_activate;
    @(posedge clk_i) disable iff (rst_i)
      bus_wr && hit_ctrl && avs_byteenable_i[0] && avs_writedata_i[0] |=>
        st_reg == SPL_ACTIVE ##1 active_o;
  endproperty
  a_activate: assert property (p_activate)
    else $error("activate not taken");
  c_activate: cover property (@(posedge clk_i) st_reg == SPL_ACTIVE);
  c_blk_rd:   cover property (@(posedge clk_i) blk_rd);
  c_reject:   cover property (@(posedge clk_i) rejected);
  c_irq:      cover property (@(posedge clk_i) irq_o);
endmodule

// *** splat_mem_model.sv ***
// Storage model at the far side of the latch: word RAM, combinational read.
// Assumes the latch forwards writes on mem_* and storage reads acc_addr_i.
module splat_mem_model
  import splat_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          acc_valid_i,
  input  wire logic [AW-1:0] acc_addr_i,
  input  wire logic          mem_write_i,
  input  wire logic [AW-1:0] mem_addr_i,
  input  wire logic [DW-1:0] mem_wdata_i,
  output logic      [DW-1:0] mem_rdata_o
);
  // ==========================================================================
  // Storage array
  logic [DW-1:0] mem_words [256];

  // Forwarded writes land on the clock edge
  always_ff @(posedge clk_i)
  begin
    if (mem_write_i)
      mem_words[mem_addr_i[9:2]] <= mem_wdata_i;
  end

  // Data is only meaningful while an access is presented
  assign mem_rdata_o = acc_valid_i ? mem_words[acc_addr_i[9:2]]
                                   : ~mem_words[acc_addr_i[9:2]];
endmodule

// *** storage_protection_latch_tb.sv ***
// Self-checking bench for the storage protection latch.
// Assumes splat_top and splat_mem_model; one 250 MHz clock.
module storage_protection_latch_tb
  import splat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals and bench state
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic [BAW-1:0] adr = 8'h00;
  logic           rd = 1'b0;
  logic           wr = 1'b0;
  logic [DW-1:0]  wdat = 32'h0;
  logic [DW-1:0]  avs_rdat;
  logic           avs_wait;
  logic [1:0]     avs_resp;
  logic           acc_valid = 1'b0;
  logic           acc_wr = 1'b0;
  logic [AW-1:0]  acc_addr = 32'h0;
  logic [DW-1:0]  acc_wdat = 32'h0;
  logic           peer_rd = 1'b0;
  logic           peer_wr = 1'b0;
  logic           done;
  logic [DW-1:0]  acc_rdat;
  logic           acc_err;
  logic           mem_wr;
  logic [AW-1:0]  mem_addr;
  logic [DW-1:0]  mem_wdat;
  logic [DW-1:0]  mem_rdat;
  logic           active;
  logic           irq;
  int             err_count = 0;
  int             check_count = 0;
  int             cyc = 0;
  int             wr_cnt = 0;
  int             n;
  logic [DW-1:0]  q;
  logic [DW-1:0]  shadow;
  logic [DW-1:0]  cfg;
  logic [1:0]     r;
  logic           e;
  logic           brd;
  logic           bwr;
  logic           lr;
  logic           lw;
  // Per-pass settings: mode, read answer, write answer, logging
  logic [1:0]     md [4] = '{2'h2, 2'h1, 2'h0, 2'h2};
  logic [1:0]     rr [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
  logic           ws [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  logic [1:0]     lg [4] = '{2'h2, 2'h1, 2'h0, 2'h3};

  // ==========================================================================
  // Design, storage model, clock
  splat_top i_dut (.clk_i(clk), .rst_i(rst), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hf),
    .avs_writedata_i(wdat), .avs_readdata_o(avs_rdat),
    .avs_waitrequest_o(avs_wait), .avs_response_o(avs_resp),
    .acc_valid_i(acc_valid), .acc_write_i(acc_wr), .acc_addr_i(acc_addr),
    .acc_wdata_i(acc_wdat), .peer_block_rd_i(peer_rd),
    .peer_block_wr_i(peer_wr), .acc_done_o(done), .acc_rdata_o(acc_rdat),
    .acc_error_o(acc_err), .mem_write_o(mem_wr), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdat), .mem_rdata_i(mem_rdat), .active_o(active),
    .irq_o(irq));

  splat_mem_model i_mem (.clk_i(clk), .acc_valid_i(acc_valid),
    .acc_addr_i(acc_addr), .mem_write_i(mem_wr), .mem_addr_i(mem_addr),
    .mem_wdata_i(mem_wdat), .mem_rdata_o(mem_rdat));

  // Free-running clock, 4 ns period
  initial
  begin
    forever #2 clk = ~clk;
  end

  // Forwarded write counter and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (mem_wr === 1'b1)
      wr_cnt <= wr_cnt + 1;
    if (cyc == 5000)
    begin
      err_count++;
      finish_test();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic finish_test();
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Avalon cycle held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [DW-1:0] d, output logic [DW-1:0] qq,
                     output logic [1:0] rs);
    @(posedge clk);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wdat <= d;
    do
      @(posedge clk);
    while (avs_wait !== 1'b0);
    qq = avs_rdat;
    rs = avs_resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Register access; d is write data or expected read data
  task automatic rio(input logic w, input logic [7:0] a,
                     input logic [DW-1:0] d, input logic [1:0] er);
    logic [DW-1:0] qq;
    logic [1:0]    rs;
    bus(w, a, d, qq, rs);
    if (!w)
      chk(qq, d);
    chk({30'h0, rs}, {30'h0, er});
  endtask

  // One-cycle storage access, answer one cycle later
  task automatic acc(input logic w, input logic [AW-1:0] a,
                     input logic [DW-1:0] d);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_wr <= w;
    acc_addr <= a;
    acc_wdat <= d;
    @(posedge clk);
    acc_valid <= 1'b0;
    @(negedge clk);
    chk({31'h0, done}, 32'h1);
    q = acc_rdat;
    e = acc_err;
    repeat (2) @(posedge clk);
  endtask

  // ==========================================================================
  // Main sequence: one pass per protection setting
  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rio(1'b0, OFS_CTRL, 32'h0, 2'h0);
      rio(1'b0, OFS_CFG, CFG_RST, 2'h0);
      shadow = 32'h0bad_f000 | 32'(m);
      acc(1'b1, 32'h120, shadow);
      acc(1'b0, 32'h120, 32'h0);
      chk(q, shadow);
      rio(1'b1, OFS_RGN, 32'h100, 2'h0);
      rio(1'b1, OFS_RGN + 8'h04, 32'h1ff, 2'h0);
      cfg = {20'h0, 4'h1, 1'b0, lg[m], ws[m], rr[m], md[m]};
      rio(1'b1, OFS_CFG, cfg, 2'h0);
      rio(1'b0, OFS_CFG, cfg, 2'h0);
      rio(1'b1, OFS_IRQ_MK, 32'h7, 2'h0);
      rio(1'b1, OFS_CTRL, 32'h1, 2'h0);
      rio(1'b0, OFS_STATUS, 32'h3, 2'h0);
      chk({31'h0, active}, 32'h1);
      brd = (md[m] != 2'h1);
      bwr = (md[m] != 2'h0);
      acc(1'b0, 32'h120, 32'h0);
      if (!brd)
        chk(q, shadow);
      else if (rr[m] == RRSP_PAT)
        chk(q, PATTERN);
      else if (rr[m] == RRSP_ERR)
        chk(q, 32'h0);
      else
        chk({31'h0, q === shadow}, 32'h0);
      chk({31'h0, e}, {31'h0, brd && rr[m] == RRSP_ERR});
      n = wr_cnt;
      acc(1'b1, 32'h120, 32'h7777_0000);
      chk(32'(wr_cnt - n), {31'h0, !bwr});
      chk({31'h0, e}, {31'h0, bwr && ws[m]});
      if (!bwr)
        shadow = 32'h7777_0000;
      if (!brd)
      begin
        acc(1'b0, 32'h120, 32'h0);
        chk(q, shadow);
      end
      lr = brd && (lg[m] == SPL_LOG_RD || lg[m] == SPL_LOG_BOTH);
      lw = bwr && (lg[m] == SPL_LOG_WR || lg[m] == SPL_LOG_BOTH);
      rio(1'b0, OFS_IRQ_ST, {30'h0, lw, lr}, 2'h0);
      rio(1'b0, OFS_LOGI, {31'h0, lr} + {31'h0, lw}, 2'h0);
      if (lr | lw)
        rio(1'b0, OFS_LOGA, 32'h120, 2'h0);
      chk({31'h0, irq}, {31'h0, lr | lw});
      rio(1'b1, OFS_IRQ_ST, 32'h3, 2'h0);
      rio(1'b0, OFS_IRQ_ST, 32'h0, 2'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      if (m == 0)
      begin
        rio(1'b1, OFS_CFG, 32'h0, 2'h3);
        rio(1'b0, OFS_CFG, cfg, 2'h0);
        rio(1'b0, OFS_IRQ_ST, 32'h4, 2'h0);
        bus(1'b1, OFS_CTRL, 32'h0, q, r);
        rio(1'b0, OFS_CTRL, 32'h1, 2'h0);
        rio(1'b1, OFS_RGN, 32'h180, 2'h3);
        rio(1'b0, OFS_RGN, 32'h100, 2'h0);
        rio(1'b1, OFS_RGN + 8'h04, 32'h2ff, 2'h0);
        acc(1'b0, 32'h280, 32'h0);
        chk(q, PATTERN);
        n = wr_cnt;
        peer_wr <= 1'b1;
        acc(1'b1, 32'h300, 32'h1);
        peer_wr <= 1'b0;
        chk(32'(wr_cnt - n), 32'h0);
        // Another latch blocking reads outside our own region
        peer_rd <= 1'b1;
        acc(1'b0, 32'h300, 32'h0);
        peer_rd <= 1'b0;
        chk(q, PATTERN);
        chk({31'h0, e}, 32'h0);
        rio(1'b0, 8'h30, 32'h0, 2'h3);
      end
    end
    finish_test();
  end
endmodule
